//--- bench/adcc_ctrl_tb.sv
// self-checking bench for the converter control block
`timescale 1ns/1ps
module adcc_ctrl_tb;
    import adcc_pkg::*;
    logic mclk = 0, sys_rst = 1, edge_mode = 0, fire = 0, data_oe_n;
    logic power_down_in = 0, chip_sel_n = 1, read_n = 1, ext_sclk = 0;
    logic comp_in = 0, convert_start_n, sclk_gated, busy, hold, low_power;
    logic [15:0] data_out;
    int failures = 0, cmp_count = 0, exp_res = 0, n;
    adcc_host u_adcc_host (.edge_mode, .fire, .convert_start_n);
    adcc_ctrl u_adcc_ctrl (.mclk, .sys_rst, .convert_start_n,
        .power_down_in, .chip_sel_n, .read_n, .ext_sclk, .sclk_gated,
        .comp_in, .busy, .hold, .low_power, .data_out, .data_oe_n);
    initial forever #5 mclk = ~mclk;
    task automatic check(logic [15:0] seen, logic [15:0] want);
        cmp_count++;
        if (seen !== want) begin
            failures++;
            $display("BAD %0t got %h want %h", $time, seen, want);
        end
    endtask
    task automatic finish_test();
        if (failures == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // bounded wait: n counts cycles until busy reaches lvl
    task automatic wait_busy(logic lvl, int lim);
        #1;
        for (n = 0; busy !== lvl && n < lim; n++) @(posedge mclk) #1;
    endtask
    // reference result: one comparator decision per busy cycle, msb first
    always @(posedge mclk) begin
        if (busy === 1'b1)
            exp_res = ((exp_res << 1) | comp_in) & 32'h0000ffff;
        comp_in <= 1'($urandom);
        ext_sclk <= 1'($urandom);
        chip_sel_n <= 1'($urandom);
        read_n <= 1'($urandom);
    end
    always @(negedge mclk) begin
        check(data_oe_n, chip_sel_n | read_n);
        check(sclk_gated, ext_sclk & ~chip_sel_n);
        check(hold, busy);
    end
    initial begin
        #20000;
        failures++;
        finish_test();
    end
    initial begin
        void'($urandom(32'h3900));
        repeat (5) @(posedge mclk);
        sys_rst <= 0;
        wait_busy(1, 120);
        check(n, ACQ_CYCLES + 1);
        wait_busy(0, 20);
        check(n, CONV_STEPS);
        check(data_out, exp_res[15:0]);
        // start held high past acquisition end must wait for an edge
        @(posedge mclk) edge_mode <= 1;
        wait_busy(1, 150);
        check(n, 150);
        @(posedge mclk) fire <= 1;
        @(posedge mclk) fire <= 0;
        wait_busy(1, 5);
        check(n, 0);
        // power-down in mid-conversion: finish, then refuse starts
        @(posedge mclk) power_down_in <= 1;
        edge_mode <= 0;
        wait_busy(0, 20);
        check(n, CONV_STEPS - 1);
        check(data_out, exp_res[15:0]);
        wait_busy(1, 200);
        check(n, 200);
        check(low_power, 1);
        @(posedge mclk) power_down_in <= 0;
        wait_busy(1, 120);
        check(n, ACQ_CYCLES + 2);
        check(low_power, 0);
        // reset in mid-conversion aborts without a result
        repeat (4) @(posedge mclk);
        sys_rst <= 1;
        @(posedge mclk) #1;
        check(busy, 0);
        check(data_out, RESULT_RST);
        @(posedge mclk) sys_rst <= 0;
        wait_busy(1, 120);
        check(n, ACQ_CYCLES + 1);
        wait_busy(0, 20);
        check(n, CONV_STEPS);
        check(data_out, exp_res[15:0]);
        finish_test();
    end
endmodule // adcc_ctrl_tb

//--- bench/adcc_host.sv
// host-side model that drives the conversion start line
`timescale 1ns/1ps
module adcc_host (
    // control from the bench
    input wire logic edge_mode,
    input wire logic fire,
    // start line to the converter
    output logic convert_start_n
);
    // level mode holds the line low; edge mode pulses it low on request
    assign convert_start_n = edge_mode & ~fire;
endmodule // adcc_host

//--- inc/adcc_pkg.sv
// package: constants for the converter control block
package adcc_pkg;
    // acquisition phase length, in ns, and its cycle count at 100 MHz
    localparam int ACQ_TIME_NS = 1000;
    localparam int CLK_PERIOD_NS = 10;
    localparam int ACQ_CYCLES = (ACQ_TIME_NS + CLK_PERIOD_NS - 1) /
        CLK_PERIOD_NS;
    // successive approximation: one step per result bit
    localparam int RESULT_BITS = 16;
    localparam logic [4:0] CONV_STEPS = 5'h10;
    localparam logic [15:0] RESULT_RST = 16'h0000;
    typedef enum logic [1:0] {
        ADCC_ACQ,
        ADCC_WAIT_EDGE,
        ADCC_CONV,
        ADCC_PWRDN
    } adcc_state_type;
endpackage

//--- rtl/adcc_ctrl.sv
// converter control: start, busy, power-down and output gating
`timescale 1ns/1ps
module adcc_ctrl
    import adcc_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // host control
    input wire logic convert_start_n,
    input wire logic power_down_in,
    input wire logic chip_sel_n,
    input wire logic read_n,
    // external serial clock
    input wire logic ext_sclk,
    output logic sclk_gated,
    // comparator decision from the analog core
    input wire logic comp_in,
    // status and data
    output logic busy,
    output logic hold,
    output logic low_power,
    output logic [15:0] data_out,
    output logic data_oe_n
);
    adcc_state_type state_q;
    logic [$clog2(ACQ_CYCLES+1)-1:0] acq_cnt_q;
    logic [4:0] step_q;
    logic [15:0] sar_q;
    logic [15:0] result_q;
    logic start_prev_q;
    logic acq_done;
    logic start_fall;

    assign acq_done = (acq_cnt_q == ($bits(acq_cnt_q))'(ACQ_CYCLES));
    assign start_fall = start_prev_q && !convert_start_n;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            start_prev_q <= 1'b1;
        end else begin
            start_prev_q <= convert_start_n;
        end
    end

    // phase sequencing; reset drops any conversion and its partial result
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state_q <= ADCC_ACQ;
        end else begin
            case (state_q)
                ADCC_ACQ: begin
                    if (power_down_in) begin
                        state_q <= ADCC_PWRDN;
                    end else if (acq_done) begin
                        if (!convert_start_n) begin
                            state_q <= ADCC_CONV;
                        end else begin
                            state_q <= ADCC_WAIT_EDGE;
                        end
                    end
                end
                ADCC_WAIT_EDGE: begin
                    if (power_down_in) begin
                        state_q <= ADCC_PWRDN;
                    end else if (start_fall) begin
                        state_q <= ADCC_CONV;
                    end
                end
                ADCC_CONV: begin
                    // power-down is not looked at here: the conversion ends
                    if (step_q == CONV_STEPS - 5'h01) begin
                        state_q <= ADCC_ACQ;
                    end
                end
                ADCC_PWRDN: begin
                    if (!power_down_in) begin
                        state_q <= ADCC_ACQ;
                    end
                end
                default: state_q <= ADCC_ACQ;
            endcase
        end
    end

    // acquisition timer restarts whenever the track phase is re-entered
    always_ff @(posedge mclk) begin
        if (sys_rst || state_q != ADCC_ACQ) begin
            acq_cnt_q <= '0;
        end else if (!acq_done) begin
            acq_cnt_q <= acq_cnt_q + 1'b1;
        end
    end

    // successive approximation, msb first
    always_ff @(posedge mclk) begin
        if (sys_rst || state_q != ADCC_CONV) begin
            step_q <= 5'h00;
            sar_q <= RESULT_RST;
        end else begin
            step_q <= step_q + 5'h01;
            sar_q[4'(RESULT_BITS - 1) - step_q[3:0]] <= comp_in;
        end
    end

    // result latched on the last step; an aborted one never gets here
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            result_q <= RESULT_RST;
        end else if (state_q == ADCC_CONV &&
                     step_q == CONV_STEPS - 5'h01) begin
            result_q <= sar_q;
            result_q[4'(RESULT_BITS - 1) - step_q[3:0]] <= comp_in;
        end
    end

    assign busy = (state_q == ADCC_CONV);
    assign hold = (state_q == ADCC_CONV);
    assign low_power = (state_q == ADCC_PWRDN);
    assign data_out = result_q;
    assign data_oe_n = !(!chip_sel_n && !read_n);
    // plain gate: a glitch-free clock gate would need a latch cell
    assign sclk_gated = ext_sclk & !chip_sel_n;

    property p_oe_gate;
        @(posedge mclk) disable iff (sys_rst)
        (chip_sel_n || read_n) |-> data_oe_n;
    endproperty
    a_oe_gate: assert property (p_oe_gate)
        else $error("output enabled without select and read");

    property p_sclk_gate;
        @(posedge mclk) disable iff (sys_rst)
        chip_sel_n |-> !sclk_gated;
    endproperty
    a_sclk_gate: assert property (p_sclk_gate)
        else $error("serial clock passed while deselected");

    property p_reset_abort;
        @(posedge mclk) sys_rst |=> (!busy && result_q == RESULT_RST);
    endproperty
    a_reset_abort: assert property (p_reset_abort)
        else $error("reset did not abort conversion");

    property p_pd_finish;
        @(posedge mclk) disable iff (sys_rst)
        (busy && power_down_in && step_q != CONV_STEPS - 5'h01) |=> busy;
    endproperty
    a_pd_finish: assert property (p_pd_finish)
        else $error("power-down cut a conversion short");

    property p_pd_block;
        @(posedge mclk) disable iff (sys_rst)
        (low_power && power_down_in) |=> !busy;
    endproperty
    a_pd_block: assert property (p_pd_block)
        else $error("conversion started in power-down");

    property p_edge_start;
        @(posedge mclk) disable iff (sys_rst)
        (state_q == ADCC_WAIT_EDGE && !power_down_in && start_fall)
            |=> busy && hold;
    endproperty
    a_edge_start: assert property (p_edge_start)
        else $error("falling start edge did not begin conversion");

    property p_wait_edge;
        @(posedge mclk) disable iff (sys_rst)
        (state_q == ADCC_WAIT_EDGE && !start_fall) |=> !busy;
    endproperty
    a_wait_edge: assert property (p_wait_edge)
        else $error("conversion began without a start edge");

    property p_immediate;
        @(posedge mclk) disable iff (sys_rst)
        (state_q == ADCC_ACQ && acq_done && !convert_start_n &&
         !power_down_in) |=> busy;
    endproperty
    a_immediate: assert property (p_immediate)
        else $error("low start did not convert at once");

    property p_busy_len;
        @(posedge mclk) disable iff (sys_rst)
        $rose(busy) |-> busy [*8] ##1 busy [*8] ##1 !busy;
    endproperty
    a_busy_len: assert property (p_busy_len)
        else $error("busy did not last sixteen cycles");

    property p_after_reset;
        @(posedge mclk) $fell(sys_rst) |-> state_q == ADCC_ACQ && !busy;
    endproperty
    a_after_reset: assert property (p_after_reset)
        else $error("not in acquisition after reset");

    property p_result_latch;
        @(posedge mclk) disable iff (sys_rst)
        (busy && step_q == CONV_STEPS - 5'h01) |=>
            !busy && (data_out >> 1) == ($past(sar_q) >> 1) &&
            data_out[0] == $past(comp_in);
    endproperty
    a_result_latch: assert property (p_result_latch)
        else $error("result not latched when busy fell");

    property p_acq_refuse;
        @(posedge mclk) disable iff (sys_rst)
        (state_q == ADCC_ACQ && !acq_done) |=> !busy;
    endproperty
    a_acq_refuse: assert property (p_acq_refuse)
        else $error("conversion started before acquisition ended");

    property p_pd_enter;
        @(posedge mclk) disable iff (sys_rst)
        (!busy && power_down_in) |=> low_power && !busy;
    endproperty
    a_pd_enter: assert property (p_pd_enter)
        else $error("power-down not entered while idle");

    property p_pd_leave;
        @(posedge mclk) disable iff (sys_rst)
        (low_power && !power_down_in) |=> !low_power && !busy;
    endproperty
    a_pd_leave: assert property (p_pd_leave)
        else $error("power-down not left on release");
endmodule // adcc_ctrl
